// ### rtl/mute_ramp_defines.svh
// register map, field positions, reset values and counts of the mute ramp block
`ifndef MUTE_RAMP_DEFINES_SVH
`define MUTE_RAMP_DEFINES_SVH

// register addresses on the 16-bit control port
`define MR_LOCK_ADDR 16'hf580
`define MR_CTRL_ADDR 16'hf581
`define MR_STAT_ADDR 16'hf582

// reset values
`define MR_CTRL_RESET 16'h0000
`define MR_LOCK_RESET 8'h00

// control field positions
`define MR_MANUAL_LSB 0
`define MR_GRP0_BIT 8
`define MR_GRP1_BIT 9
`define MR_MUTE_ON_LOCK_LOSS_BIT 10

// ramp and gain figures
`define MR_RAMP_SAMPLES 2048
`define MR_GAIN_FULL 12'h800
`define MR_GAIN_ZERO 12'h000
`define MR_GAIN_STEP 12'h001
`define MR_FRAC_BITS 11

// structure defaults
`define MR_NUM_CONV 8
`define MR_CONV_PER_GROUP 4
`define MR_FIFO_DEPTH 8
`define MR_SAMPLE_W 24

`endif

// ### rtl/mute_ramp_pkg.sv
// types shared by the mute ramp block
package mute_ramp_pkg;

  // linear gain, 2048 means unity
  typedef logic [11:0] gain_type;

  // converter index carried with each sample
  typedef logic [2:0] conv_idx_type;

endpackage

// ### rtl/sample_stream_if.sv
// valid/ready sample stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none

interface sample_stream_if #(
  parameter int W = 51
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  // producer side
  modport src (output valid, output data, input ready);
  // consumer side
  modport snk (input valid, input data, output ready);
endinterface // sample_stream_if

`default_nettype wire

// ### rtl/sample_fifo.sv
// flip-flop fifo with registered ready and valid flags
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int W = 51,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,    // system clock
  input wire logic arst_n_i,  // async reset, active low
  sample_stream_if.snk in_if, // filling side
  sample_stream_if.src out_if // draining side
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic ready_r, ready_nxt, valid_r, valid_nxt;
  logic push, pop;

  // flags are registered so the ports come from flip-flops
  assign in_if.ready = ready_r;
  assign out_if.valid = valid_r;
  assign out_if.data = mem_r[rptr_r];

  // next pointers, count, storage and flags
  always_comb
  begin
    push = in_if.valid && ready_r;
    pop = out_if.ready && valid_r;
    mem_nxt = mem_r;
    if (push)
    begin
      mem_nxt[wptr_r] = in_if.data;
    end
    wptr_nxt = push ? PW'(wptr_r + 1'b1) : wptr_r;
    rptr_nxt = pop ? PW'(rptr_r + 1'b1) : rptr_r;
    count_nxt = CW'(count_r + CW'(push) - CW'(pop));
    ready_nxt = (count_nxt != CW'(DEPTH));
    valid_nxt = (count_nxt != '0);
  end

  // state registers
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= '0;
      end
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      count_r <= count_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
    end
  end
endmodule // sample_fifo

`default_nettype wire

// ### rtl/converter_mute_ramp.sv
// mute and linear gain ramp control for eight stereo converters
//
// Decided for this implementation: the plain strobed port.
`include "mute_ramp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module converter_mute_ramp #(
  parameter int SW = `MR_SAMPLE_W,
  parameter int NUM_CONV = `MR_NUM_CONV,
  parameter int FIFO_DEPTH = `MR_FIFO_DEPTH
) (
  input wire logic mclk_i,                  // 100 MHz clock
  input wire logic arst_n_i,                // async reset, active low
  input wire logic [15:0] reg_addr_i,       // register address
  input wire logic [15:0] reg_wdata_i,      // register write data
  input wire logic reg_wr_i,                // write strobe
  input wire logic reg_rd_i,                // read strobe
  output logic [15:0] reg_rdata_o,          // read data, cycle after strobe
  input wire logic [NUM_CONV-1:0] rate_set_i,    // output rate set
  input wire logic [NUM_CONV-1:0] rate_steady_i, // input rate detected
  input wire logic [NUM_CONV-1:0] ratio_done_i,  // rate ratio calculated
  input wire logic in_valid_i,              // input sample valid
  output logic in_ready_o,                  // fifo can take a sample
  input wire logic [2:0] in_conv_i,         // converter of input sample
  input wire logic [SW-1:0] in_left_i,      // left sample, signed
  input wire logic [SW-1:0] in_right_i,     // right sample, signed
  output logic out_valid_o,                 // output sample valid
  input wire logic out_ready_i,             // consumer takes sample
  output logic [2:0] out_conv_o,            // converter of output sample
  output logic [SW-1:0] out_left_o,         // scaled left sample
  output logic [SW-1:0] out_right_o         // scaled right sample
);
  localparam int FW = 3 + 2 * SW;
  localparam int PW = SW + 13;

  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [NUM_CONV-1:0] set_s1_r, set_s2_r, std_s1_r, std_s2_r;
  logic [NUM_CONV-1:0] rat_s1_r, rat_s2_r;
  logic [NUM_CONV-1:0] unlocked_r, unlocked_nxt;
  logic [NUM_CONV-1:0] mute_req;
  logic [NUM_CONV-1:0] fully_muted;
  logic [NUM_CONV-1:0] ramping;
  mute_ramp_pkg::gain_type [NUM_CONV-1:0] gain_vec;
  logic out_valid_r, out_valid_nxt;
  logic [2:0] out_conv_r, out_conv_nxt;
  logic [SW-1:0] out_left_r, out_left_nxt, out_right_r, out_right_nxt;
  logic take;
  logic step_any;
  mute_ramp_pkg::conv_idx_type pop_conv;
  logic [SW-1:0] pop_left, pop_right;

  sample_stream_if #(.W(FW)) fill_if ();
  sample_stream_if #(.W(FW)) drain_if ();

  // input samples enter the fifo packed with their converter index
  assign fill_if.valid = in_valid_i;
  assign fill_if.data = {in_conv_i, in_left_i, in_right_i};

  sample_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) i_sample_fifo (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .in_if(fill_if),
    .out_if(drain_if)
  );

  // drain when the output register is free or being emptied
  assign drain_if.ready = !out_valid_r || out_ready_i;
  assign take = drain_if.valid && drain_if.ready;
  assign step_any = take;
  assign pop_conv = drain_if.data[FW-1 -: 3];
  assign pop_left = drain_if.data[2*SW-1 -: SW];
  assign pop_right = drain_if.data[SW-1:0];

  // control register write and read answer
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = 16'h0000;
    if (reg_wr_i && reg_addr_i == `MR_CTRL_ADDR)
    begin
      ctrl_nxt = reg_wdata_i;
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `MR_CTRL_ADDR: rdata_nxt = ctrl_r;
        `MR_LOCK_ADDR: rdata_nxt = {8'h00, unlocked_r};
        `MR_STAT_ADDR: rdata_nxt = {ramping, fully_muted};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_r <= `MR_CTRL_RESET;
      rdata_r <= 16'h0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // lock conditions arrive from another domain, two flops before use
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      set_s1_r <= '0;
      set_s2_r <= '0;
      std_s1_r <= '0;
      std_s2_r <= '0;
      rat_s1_r <= '0;
      rat_s2_r <= '0;
    end
    else
    begin
      set_s1_r <= rate_set_i;
      set_s2_r <= set_s1_r;
      std_s1_r <= rate_steady_i;
      std_s2_r <= std_s1_r;
      rat_s1_r <= ratio_done_i;
      rat_s2_r <= rat_s1_r;
    end
  end

  // locked only when all three conditions hold
  always_comb
  begin
    unlocked_nxt = ~(set_s2_r & std_s2_r & rat_s2_r);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      unlocked_r <= `MR_LOCK_RESET;
    end
    else
    begin
      unlocked_r <= unlocked_nxt;
    end
  end

  // per converter mute request and gain ramp
  for (genvar n = 0; n < NUM_CONV; n++)
  begin : g_conv
    logic grp_off;
    mute_ramp_pkg::gain_type gain_r, gain_nxt;

    // group bit n/4 disables ramping and every kind of mute
    assign grp_off = ctrl_r[`MR_GRP0_BIT + n / `MR_CONV_PER_GROUP];
    // manual mute first, then the lock-loss mute if enabled
    assign mute_req[n] = !grp_off && (ctrl_r[`MR_MANUAL_LSB + n]
      || (ctrl_r[`MR_MUTE_ON_LOCK_LOSS_BIT] && unlocked_r[n]));
    assign gain_vec[n] = gain_r;
    assign fully_muted[n] = (gain_r == `MR_GAIN_ZERO);
    assign ramping[n] = mute_req[n] ? (gain_r != `MR_GAIN_ZERO)
                                    : (gain_r != `MR_GAIN_FULL);

    // one step per sample of this converter, toward the requested end
    always_comb
    begin
      gain_nxt = gain_r;
      if (grp_off)
      begin
        gain_nxt = `MR_GAIN_FULL;
      end
      else if (step_any && pop_conv == 3'(n))
      begin
        if (mute_req[n] && gain_r != `MR_GAIN_ZERO)
        begin
          gain_nxt = gain_r - `MR_GAIN_STEP;
        end
        else if (!mute_req[n] && gain_r != `MR_GAIN_FULL)
        begin
          gain_nxt = gain_r + `MR_GAIN_STEP;
        end
      end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        gain_r <= `MR_GAIN_FULL;
      end
      else
      begin
        gain_r <= gain_nxt;
      end
    end
  end

  // scale a signed sample by the linear gain
  function automatic logic [SW-1:0] scale(
    input logic [SW-1:0] s,
    input mute_ramp_pkg::gain_type g
  );
    logic signed [PW-1:0] prod;
    prod = PW'($signed(s) * $signed({1'b0, g}));
    scale = SW'(prod >>> `MR_FRAC_BITS);
  endfunction

  // output stage, gain applied as the sample leaves the fifo
  always_comb
  begin
    out_valid_nxt = out_valid_r;
    out_conv_nxt = out_conv_r;
    out_left_nxt = out_left_r;
    out_right_nxt = out_right_r;
    if (take)
    begin
      out_valid_nxt = 1'b1;
      out_conv_nxt = pop_conv;
      out_left_nxt = scale(pop_left, gain_vec[pop_conv]);
      out_right_nxt = scale(pop_right, gain_vec[pop_conv]);
    end
    else if (out_ready_i)
    begin
      out_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      out_valid_r <= 1'b0;
      out_conv_r <= 3'h0;
      out_left_r <= '0;
      out_right_r <= '0;
    end
    else
    begin
      out_valid_r <= out_valid_nxt;
      out_conv_r <= out_conv_nxt;
      out_left_r <= out_left_nxt;
      out_right_r <= out_right_nxt;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_o = rdata_r;
  assign in_ready_o = fill_if.ready;
  assign out_valid_o = out_valid_r;
  assign out_conv_o = out_conv_r;
  assign out_left_o = out_left_r;
  assign out_right_o = out_right_r;

  // checks on the block's own behaviour
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  // a control write is read back in the cycle after a following read
  property p_ctrl_readback;
    (reg_wr_i && reg_addr_i == `MR_CTRL_ADDR) ##1
      (reg_rd_i && reg_addr_i == `MR_CTRL_ADDR && !reg_wr_i)
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control register read back differs from write");

  // manual mute on an enabled group asks for mute whatever the lock
  property p_manual_mute;
    (ctrl_r[0] && !ctrl_r[`MR_GRP0_BIT]) |-> mute_req[0];
  endproperty
  a_manual_mute: assert property (p_manual_mute)
    else $error("manual mute bit not honoured");

  // group 1 bit drops the request at once and forces full gain next cycle
  property p_group1_active;
    ctrl_r[`MR_GRP1_BIT] |-> !mute_req[7] ##1 gain_vec[7] == `MR_GAIN_FULL;
  endproperty
  a_group1_active: assert property (p_group1_active)
    else $error("group 1 converter not held active");

  // group 0 bit drops the request at once and forces full gain next cycle
  property p_group0_active;
    ctrl_r[`MR_GRP0_BIT] |-> !mute_req[0] ##1 gain_vec[0] == `MR_GAIN_FULL;
  endproperty
  a_group0_active: assert property (p_group0_active)
    else $error("group 0 converter not held active");

  // a sample of converter 0 under mute lowers gain by exactly one step
  property p_ramp_down_step;
    (take && pop_conv == 3'h0 && mute_req[0] && !ctrl_r[`MR_GRP0_BIT]
      && gain_vec[0] != `MR_GAIN_ZERO)
      |=> gain_vec[0] == $past(gain_vec[0]) - `MR_GAIN_STEP;
  endproperty
  a_ramp_down_step: assert property (p_ramp_down_step)
    else $error("ramp down step wrong");

  // gain of an enabled converter only moves on its own samples
  property p_step_per_sample;
    (!ctrl_r[`MR_GRP0_BIT] && !(take && pop_conv == 3'h0))
      ##1 !ctrl_r[`MR_GRP0_BIT] |-> $stable(gain_vec[0]);
  endproperty
  a_step_per_sample: assert property (p_step_per_sample)
    else $error("gain moved without a sample");

  // lock loss never mutes while the lock-mute bit is clear
  property p_no_lock_mute;
    (!ctrl_r[`MR_MUTE_ON_LOCK_LOSS_BIT] && !ctrl_r[3]) |-> !mute_req[3];
  endproperty
  a_no_lock_mute: assert property (p_no_lock_mute)
    else $error("mute without manual bit or lock-mute");

  // an enabled converter never drops gain by more than one step
  property p_no_cut;
    (!ctrl_r[`MR_GRP0_BIT] ##1 !ctrl_r[`MR_GRP0_BIT])
      |-> gain_vec[1] + `MR_GAIN_STEP >= $past(gain_vec[1]);
  endproperty
  a_no_cut: assert property (p_no_cut)
    else $error("gain cut instead of ramped");

  // returning lock clears the request unless manually muted
  property p_relock_unmute;
    (ctrl_r[`MR_MUTE_ON_LOCK_LOSS_BIT] && !ctrl_r[2] && !unlocked_r[2]) |-> !mute_req[2];
  endproperty
  a_relock_unmute: assert property (p_relock_unmute)
    else $error("mute held after lock returned");

  // lock status follows the three synchronised conditions
  property p_lock_status;
    (rate_set_i[4] && rate_steady_i[4] && ratio_done_i[4]) [*4]
      |-> !unlocked_r[4];
  endproperty
  a_lock_status: assert property (p_lock_status)
    else $error("lock status not low with all conditions met");

  // main scenarios
  c_full_mute: cover property (mute_req[3] ##1 gain_vec[3] == `MR_GAIN_ZERO);
  c_lock_mute: cover property (ctrl_r[`MR_MUTE_ON_LOCK_LOSS_BIT] && unlocked_r[1]
    && !ctrl_r[1] && !ctrl_r[`MR_GRP0_BIT] && mute_req[1]);
  c_reverse: cover property (mute_req[0] && ramping[0] ##1 !mute_req[0]);
  c_fifo_full: cover property (in_valid_i && !in_ready_o);
endmodule // converter_mute_ramp

`default_nettype wire

// ### dv/conv_source.sv
// behavioural converter side: sample source and lock conditions
`timescale 1ns/1ps
`default_nettype none

module conv_source (
  input wire logic mclk_i,          // system clock
  input wire logic in_ready_i,      // block can take a sample
  output logic in_valid_o,          // sample offered
  output logic [2:0] in_conv_o,     // converter of the sample
  output logic [23:0] in_left_o,    // left sample
  output logic [23:0] in_right_o,   // right sample
  output logic [7:0] rate_set_o,    // output rate set
  output logic [7:0] rate_steady_o, // input rate steady
  output logic [7:0] ratio_done_o   // rate ratio calculated
);
  // idle source, every converter locked
  initial
  begin
    in_valid_o = 1'b0;
    in_conv_o = 3'h0;
    in_left_o = 24'h000000;
    in_right_o = 24'h000000;
    rate_set_o = 8'hff;
    rate_steady_o = 8'hff;
    ratio_done_o = 8'hff;
  end

  // offer one sample, give up after lim edges without ready
  task automatic send(input logic [2:0] c, input logic [23:0] l, input int lim,
    output logic ok);
    logic rdy;
    ok = 1'b0;
    @(posedge mclk_i);
    in_valid_o <= 1'b1;
    in_conv_o <= c;
    in_left_o <= l;
    in_right_o <= -l;
    while (!ok && lim > 0)
    begin
      @(negedge mclk_i);
      rdy = in_ready_i;
      @(posedge mclk_i);
      ok = (rdy === 1'b1);
      lim--;
    end
    // released data lines show the inverse, never a stale copy
    in_valid_o <= 1'b0;
    in_left_o <= ~l;
    in_right_o <= l - 24'h000001;
  endtask

  // drop or restore one of the three lock conditions of a converter
  task automatic lock_cond(input int c, input int which, input logic v);
    @(posedge mclk_i);
    case (which)
      0: rate_set_o[c] <= v;
      1: rate_steady_o[c] <= v;
      default: ratio_done_o[c] <= v;
    endcase
  endtask
endmodule // conv_source

`default_nettype wire

// ### dv/converter_mute_ramp_test.sv
// self-checking bench of the converter mute ramp block
`include "mute_ramp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module converter_mute_ramp_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic out_ready = 1'b0;
  logic [15:0] rdata;
  logic in_valid, in_ready, out_valid, ok;
  logic [2:0] in_conv, out_conv;
  logic [23:0] in_left, in_right, out_left, out_right;
  logic [7:0] rate_set, rate_steady, ratio_done;
  int fail_count = 0;
  int check_count = 0;

  // block and converter-side model
  converter_mute_ramp i_converter_mute_ramp (
    .mclk_i(mclk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rate_set_i(rate_set),
    .rate_steady_i(rate_steady), .ratio_done_i(ratio_done), .in_valid_i(in_valid),
    .in_ready_o(in_ready), .in_conv_i(in_conv), .in_left_i(in_left),
    .in_right_i(in_right), .out_valid_o(out_valid), .out_ready_i(out_ready),
    .out_conv_o(out_conv), .out_left_o(out_left), .out_right_o(out_right));
  conv_source i_conv_source (
    .mclk_i(mclk), .in_ready_i(in_ready), .in_valid_o(in_valid), .in_conv_o(in_conv),
    .in_left_o(in_left), .in_right_o(in_right), .rate_set_o(rate_set),
    .rate_steady_o(rate_steady), .ratio_done_o(ratio_done));

  // 100 MHz clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check("register read", {8'h00, rdata}, {8'h00, exp});
  endtask

  // write, then read the same register on the very next edge
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check("read after write", {8'h00, rdata}, {8'h00, v});
  endtask

  // wait for an output sample, compare it against gain g, then accept it
  task automatic take(input logic [2:0] c, input logic [11:0] g);
    int t;
    t = 0;
    @(negedge mclk);
    while (out_valid !== 1'b1 && t < 40)
    begin
      @(negedge mclk);
      t++;
    end
    check("output valid", {23'h0, out_valid}, 24'h000001);
    check("output converter", {21'h0, out_conv}, {21'h0, c});
    check("left sample", out_left, {12'h000, g});
    check("right sample", out_right, -{12'h000, g});
    @(posedge mclk);
    out_ready <= 1'b1;
    @(posedge mclk);
    out_ready <= 1'b0;
  endtask

  // n unit samples through converter c, gain starting at g0 and moving by dir
  task automatic ramp(input int c, input int g0, input int dir, input int n);
    int g;
    for (int k = 0; k < n; k++)
    begin
      g = g0 + dir * k;
      g = (g < 0) ? 0 : ((g > `MR_RAMP_SAMPLES) ? `MR_RAMP_SAMPLES : g);
      i_conv_source.send(3'(c), 24'h000800, 40, ok);
      take(3'(c), g[11:0]);
    end
  endtask

  task automatic t_reset();
    rd_chk(`MR_CTRL_ADDR, `MR_CTRL_RESET);
    rd_chk(`MR_LOCK_ADDR, 16'h0000);
    rd_chk(16'hf583, 16'h0000);
    wr_reg(`MR_CTRL_ADDR, 16'hf800);
    rd_chk(`MR_CTRL_ADDR, 16'hf800);
    wr_rd(`MR_CTRL_ADDR, 16'h5a5a);
    wr_reg(`MR_CTRL_ADDR, 16'h0000);
  endtask

  task automatic t_manual();
    wr_reg(`MR_CTRL_ADDR, 16'h0008);
    ramp(2, 2048, 0, 2);
    ramp(3, 2048, -1, 2049);
    rd_chk(`MR_STAT_ADDR, 16'h0008);
    wr_reg(`MR_CTRL_ADDR, 16'h0000);
    ramp(3, 0, 1, 2049);
  endtask

  task automatic t_reverse();
    wr_reg(`MR_CTRL_ADDR, 16'h0020);
    ramp(5, 2048, -1, 100);
    rd_chk(`MR_STAT_ADDR, 16'h2000);
    wr_reg(`MR_CTRL_ADDR, 16'h0000);
    ramp(5, 1948, 1, 101);
  endtask

  task automatic t_group();
    wr_reg(`MR_CTRL_ADDR, 16'h02ff);
    for (int c = 4; c < 8; c++)
      ramp(c, 2048, 0, 2);
    ramp(0, 2048, -1, 3);
    wr_reg(`MR_CTRL_ADDR, 16'h03ff);
    ramp(0, 2048, 0, 2);
    wr_reg(`MR_CTRL_ADDR, 16'h0000);
  endtask

  task automatic t_lock();
    wr_reg(`MR_CTRL_ADDR, 16'h0400);
    for (int w = 0; w < 3; w++)
    begin
      i_conv_source.lock_cond(1, w, 1'b0);
      repeat (6) @(posedge mclk);
      rd_chk(`MR_LOCK_ADDR, 16'h0002);
      i_conv_source.lock_cond(1, w, 1'b1);
      repeat (6) @(posedge mclk);
      rd_chk(`MR_LOCK_ADDR, 16'h0000);
    end
    i_conv_source.lock_cond(1, 0, 1'b0);
    repeat (6) @(posedge mclk);
    ramp(1, 2048, -1, 4);
    wr_reg(`MR_CTRL_ADDR, 16'h0402);
    i_conv_source.lock_cond(1, 0, 1'b1);
    repeat (6) @(posedge mclk);
    ramp(1, 2044, -1, 2);
    wr_reg(`MR_CTRL_ADDR, 16'h0400);
    ramp(1, 2042, 1, 7);
    i_conv_source.lock_cond(6, 2, 1'b0);
    wr_reg(`MR_CTRL_ADDR, 16'h0600);
    repeat (6) @(posedge mclk);
    ramp(6, 2048, 0, 2);
    wr_reg(`MR_CTRL_ADDR, 16'h0000);
    ramp(6, 2048, 0, 2);
    i_conv_source.lock_cond(6, 2, 1'b1);
  endtask

  // fill the buffer with the consumer stalled, then drain it
  task automatic t_fifo();
    int n;
    n = 0;
    ok = 1'b1;
    while (ok && n < 12)
    begin
      i_conv_source.send(3'h7, 24'h000800, 20, ok);
      n += int'(ok);
    end
    check("words held", n[23:0], 24'h000009);
    repeat (9) take(3'h7, `MR_GAIN_FULL);
    repeat (4) @(negedge mclk);
    check("drained", {22'h0, out_valid, in_ready}, 24'h000001);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_manual();
    t_reverse();
    t_group();
    t_lock();
    t_fifo();
    report_and_stop();
  end

  // watchdog against a hang
  initial
  begin
    repeat (80000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end
endmodule // converter_mute_ramp_test

`default_nettype wire
